// ===== ovs_pkg.sv
// constants, types and conversion helpers for the output voltage setpoint registers
package ovs_pkg;

    // ==========================================================
    // command codes
    localparam logic [7:0]  CMD_FORMAT   = 8'h20;
    localparam logic [7:0]  CMD_SETPOINT = 8'h21;
    localparam logic [7:0]  CMD_OFFSET   = 8'h22;

    // ==========================================================
    // format selector fields
    localparam int          FMT_REL_BIT  = 7;
    localparam int          FMT_MODE_HI  = 6;
    localparam int          FMT_MODE_LO  = 5;
    localparam int          FMT_EXP_HI   = 4;
    localparam int          FMT_EXP_LO   = 0;
    localparam logic [1:0]  MODE_LINEAR  = 2'h0;
    // exponent -12 and -4 in five-bit two's complement
    localparam logic [4:0]  EXP_FINE     = 5'h14;
    localparam logic [4:0]  EXP_COARSE   = 5'h1C;
    // absolute, linear, exponent -12 until storage has been loaded
    localparam logic [7:0]  FORMAT_RST   = 8'h14;

    // ==========================================================
    // internal voltage scale: one lsb at exponent -12
    localparam int          FINE_W       = 25;
    localparam int          TRIM_NVM_W   = 8;
    localparam logic signed [FINE_W-1:0] TRIM_NVM_MAX = 25'sd127;
    localparam logic signed [FINE_W-1:0] TRIM_NVM_MIN = -25'sd128;
    localparam logic signed [FINE_W-1:0] S16_MAX      = 25'sd32767;
    localparam logic signed [FINE_W-1:0] S16_MIN      = -25'sd32768;

    // ==========================================================
    // timing
    localparam int          CLK_MHZ      = 50;
    localparam int          RAMP_TICK_NS = 1000;
    localparam int          RAMP_TICK_CYC = (RAMP_TICK_NS * CLK_MHZ) / 1000;

    typedef enum logic {
        OVS_ST_LOAD,
        OVS_ST_RUN
    } ovs_state_t;

    // ==========================================================
    // exponent helpers
    function automatic logic [3:0] exp_shift(input logic [4:0] e);
        logic [4:0] d;
        d = e - EXP_FINE;
        return d[3:0];
    endfunction

    function automatic logic exp_ok(input logic [4:0] e);
        return (e >= EXP_FINE) && (e <= EXP_COARSE);
    endfunction

    function automatic logic [FINE_W-1:0] u_to_fine(input logic [15:0] m, input logic [4:0] e);
        return {9'h000, m} << exp_shift(e);
    endfunction

    function automatic logic [15:0] u_from_fine(input logic [FINE_W-1:0] f,
                                                input logic [4:0] e);
        logic [FINE_W-1:0] q;
        q = f >> exp_shift(e);
        return (|q[FINE_W-1:16]) ? 16'hFFFF : q[15:0];
    endfunction

    function automatic logic signed [FINE_W-1:0] s_to_fine(input logic [15:0] m,
                                                           input logic [4:0] e);
        logic signed [FINE_W-1:0] x;
        x = {{9{m[15]}}, m};
        return x <<< exp_shift(e);
    endfunction

    function automatic logic [15:0] s_from_fine(input logic signed [FINE_W-1:0] f,
                                                input logic [4:0] e);
        logic signed [FINE_W-1:0] q;
        q = f >>> exp_shift(e);
        if (q > S16_MAX) begin
            return 16'h7FFF;
        end
        if (q < S16_MIN) begin
            return 16'h8000;
        end
        return q[15:0];
    endfunction

endpackage

// ===== ovs_ref_ramp.sv
// slew-limited reference that walks toward the target
`timescale 1ns/100ps
`default_nettype none

module ovs_ref_ramp #(
    parameter int TICK_CYC = ovs_pkg::RAMP_TICK_CYC
) (
    input  wire logic                          sys_clk,
    input  wire logic                          rst,
    input  wire logic [ovs_pkg::FINE_W-1:0]    target,
    input  wire logic [15:0]                   slew_step,
    output logic      [ovs_pkg::FINE_W-1:0]    reference_r,
    output logic                               ramp_busy
);
    localparam int CW = $clog2(TICK_CYC + 1);

    logic [CW-1:0]                 div_r;
    logic                          tick;
    logic [ovs_pkg::FINE_W-1:0]    step_w;
    logic [ovs_pkg::FINE_W-1:0]    gap;

    // ==========================================================
    // tick divider
    assign tick = (div_r == CW'(TICK_CYC - 1));

    always_ff @(posedge sys_clk) begin
        if (rst || tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    // ==========================================================
    // one step per tick, never past the target
    assign step_w    = {9'h000, slew_step};
    assign gap       = (target > reference_r) ? target - reference_r : reference_r - target;
    assign ramp_busy = (target != reference_r);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reference_r <= '0;
        end else if (tick && ramp_busy) begin
            if (gap <= step_w) begin
                reference_r <= target;
            end else if (target > reference_r) begin
                reference_r <= reference_r + step_w;
            end else begin
                reference_r <= reference_r - step_w;
            end
        end
    end

    // ==========================================================
    // checks
    property p_ramp_rate;
        @(posedge sys_clk) disable iff (rst)
        (reference_r > $past(reference_r)) |->
            (reference_r - $past(reference_r) <= {9'h000, $past(slew_step)});
    endproperty
    a_ramp_rate: assert property (p_ramp_rate) else $error("reference rose faster than slew");

    property p_ramp_fall;
        @(posedge sys_clk) disable iff (rst)
        (reference_r < $past(reference_r)) |->
            ($past(reference_r) - reference_r <= {9'h000, $past(slew_step)});
    endproperty
    a_ramp_fall: assert property (p_ramp_fall) else $error("reference fell faster than slew");

    c_ramp_done: cover property (@(posedge sys_clk) disable iff (rst)
        ramp_busy ##1 !ramp_busy);

endmodule

`default_nettype wire

// ===== ovs_output_voltage_setpoint_regs.sv
// format selector, setpoint and offset commands with boot value, clamping and ramp
`timescale 1ns/100ps
`default_nettype none

// How it works
// - format selector answers command 20h with single-byte write and read.
// - format selector writes are ignored while conversion is enabled.
// - format byte holds relative flag bit 7, mode 6:5, parameter 4:0.
// - bit 7 chooses absolute (0) or relative (1); read/write.
// - mode reads 00 linear; any other written mode is rejected.
// - parameter is a two's-complement exponent limited to -12 through -4.
// - a format change rescales stored setpoint, offset and boot value.
// - voltage writes decode with the exponent in force at that moment.
// - setpoint is a 16-bit word register at command 21h.
// - setpoint and offset are always absolute, relative flag ignored.
// - target changes reach the reference through a slew-limited ramp.
// - reset pin, when enabled, returns setpoint to the boot voltage.
// - boot default comes from storage or voltage select pin per select bit.
// - boot voltage is held apart from the live setpoint.
// - after a fault, keep setpoint or reload default per reload bit.
// - setpoint plus offset clamps to limits; a clamped write raises a limit warning.
// - offset is a signed 16-bit word at command 22h added to setpoint.
// - offset backup is 8 bits at exponent -12, saturated to -128..127.
module ovs_output_voltage_setpoint_regs #(
    parameter int RAMP_TICK_CYC = ovs_pkg::RAMP_TICK_CYC
) (
    input  wire logic                          sys_clk,
    input  wire logic                          rst,
    input  wire logic                          cmd_valid,
    input  wire logic                          cmd_write,
    input  wire logic                          cmd_word,
    input  wire logic [7:0]                    cmd_code,
    input  wire logic [15:0]                   cmd_wdata,
    output logic                               cmd_ack,
    output logic                               cmd_error,
    output logic      [15:0]                   cmd_rdata,
    input  wire logic                          conversion_enabled,
    input  wire logic                          default_source_select,
    input  wire logic                          reload_on_fault_bit,
    input  wire logic                          reset_pin_enabled,
    input  wire logic                          power_good_or_reset_pin_n,
    input  wire logic                          fault_hiccup,
    input  wire logic                          restore_user_all,
    input  wire logic [7:0]                    nvm_format,
    input  wire logic [15:0]                   nvm_setpoint,
    input  wire logic [7:0]                    nvm_trim,
    input  wire logic [15:0]                   voltage_select_pin_value,
    input  wire logic [ovs_pkg::FINE_W-1:0]    vout_max_fine,
    input  wire logic [ovs_pkg::FINE_W-1:0]    vout_min_fine,
    input  wire logic [15:0]                   slew_step,
    output logic      [15:0]                   boot_voltage,
    output logic      [7:0]                    trim_nvm_backup,
    output logic      [ovs_pkg::FINE_W-1:0]    target_fine,
    output logic      [ovs_pkg::FINE_W-1:0]    reference_fine,
    output logic                               ramp_busy,
    output logic                               limit_warning,
    output logic                               limit_clamped
);
    ovs_pkg::ovs_state_t            state_r;
    logic [7:0]                     fmt_r;
    logic [15:0]                    sp_r;
    logic [15:0]                    trim_r;
    logic [15:0]                    boot_r;
    logic [15:0]                    rdata_r;
    logic                           ack_r;
    logic                           err_r;
    logic [1:0]                     upd_r;
    logic                           warn_r;
    logic                           clamp_r;
    logic [ovs_pkg::FINE_W-1:0]     target_r;
    logic [7:0]                     backup_r;

    logic                           run;
    logic                           boot_load;
    logic [15:0]                    boot_src;
    logic [4:0]                     load_exp;
    logic [4:0]                     cur_exp;
    logic [4:0]                     new_exp;
    logic                           is_fmt;
    logic                           is_sp;
    logic                           is_trim;
    logic                           wr_fmt;
    logic                           wr_sp;
    logic                           wr_trim;
    logic                           rd_ok;
    logic                           ext_rst_evt;
    logic                           fault_evt;
    logic signed [ovs_pkg::FINE_W:0] sum;
    logic signed [ovs_pkg::FINE_W-1:0] trim_fine;

    // ==========================================================
    // command decode
    assign run      = (state_r == ovs_pkg::OVS_ST_RUN);
    assign cur_exp  = fmt_r[ovs_pkg::FMT_EXP_HI:ovs_pkg::FMT_EXP_LO];
    assign new_exp  = cmd_wdata[ovs_pkg::FMT_EXP_HI:ovs_pkg::FMT_EXP_LO];
    assign is_fmt   = (cmd_code == ovs_pkg::CMD_FORMAT) && !cmd_word;
    assign is_sp    = (cmd_code == ovs_pkg::CMD_SETPOINT) && cmd_word;
    assign is_trim  = (cmd_code == ovs_pkg::CMD_OFFSET) && cmd_word;
    assign wr_fmt   = run && cmd_valid && cmd_write && is_fmt && !conversion_enabled
                      && (cmd_wdata[ovs_pkg::FMT_MODE_HI:ovs_pkg::FMT_MODE_LO]
                          == ovs_pkg::MODE_LINEAR)
                      && ovs_pkg::exp_ok(new_exp);
    assign wr_sp    = run && cmd_valid && cmd_write && is_sp;
    assign wr_trim  = run && cmd_valid && cmd_write && is_trim;
    assign rd_ok    = run && cmd_valid && !cmd_write && (is_fmt || is_sp || is_trim);

    // ==========================================================
    // boot source and events
    assign boot_load   = !run || restore_user_all;
    assign boot_src    = default_source_select ? voltage_select_pin_value : nvm_setpoint;
    assign load_exp    = ovs_pkg::exp_ok(nvm_format[ovs_pkg::FMT_EXP_HI:ovs_pkg::FMT_EXP_LO])
                         ? nvm_format[ovs_pkg::FMT_EXP_HI:ovs_pkg::FMT_EXP_LO]
                         : ovs_pkg::FORMAT_RST[ovs_pkg::FMT_EXP_HI:ovs_pkg::FMT_EXP_LO];
    assign ext_rst_evt = reset_pin_enabled && !power_good_or_reset_pin_n;
    assign fault_evt   = fault_hiccup && reload_on_fault_bit;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= ovs_pkg::OVS_ST_LOAD;
        end else begin
            state_r <= ovs_pkg::OVS_ST_RUN;
        end
    end

    // ==========================================================
    // format selector
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fmt_r <= ovs_pkg::FORMAT_RST;
        end else if (boot_load) begin
            fmt_r <= {nvm_format[ovs_pkg::FMT_REL_BIT], ovs_pkg::MODE_LINEAR, load_exp};
        end else if (wr_fmt) begin
            fmt_r <= {cmd_wdata[ovs_pkg::FMT_REL_BIT], ovs_pkg::MODE_LINEAR, new_exp};
        end
    end

    // ==========================================================
    // boot voltage, kept apart from the setpoint
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            boot_r <= '0;
        end else if (boot_load) begin
            boot_r <= ovs_pkg::u_from_fine({9'h000, boot_src}, load_exp);
        end else if (wr_fmt) begin
            boot_r <= ovs_pkg::u_from_fine(ovs_pkg::u_to_fine(boot_r, cur_exp), new_exp);
        end
    end

    // ==========================================================
    // setpoint
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sp_r <= '0;
        end else if (boot_load) begin
            sp_r <= ovs_pkg::u_from_fine({9'h000, boot_src}, load_exp);
        end else if (ext_rst_evt) begin
            sp_r <= boot_r;
        end else if (fault_evt) begin
            sp_r <= ovs_pkg::u_from_fine({9'h000, boot_src}, cur_exp);
        end else if (wr_fmt) begin
            sp_r <= ovs_pkg::u_from_fine(ovs_pkg::u_to_fine(sp_r, cur_exp), new_exp);
        end else if (wr_sp) begin
            sp_r <= cmd_wdata;
        end
    end

    // ==========================================================
    // offset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            trim_r <= '0;
        end else if (boot_load) begin
            trim_r <= ovs_pkg::s_from_fine({{17{nvm_trim[7]}}, nvm_trim}, load_exp);
        end else if (wr_fmt) begin
            trim_r <= ovs_pkg::s_from_fine(ovs_pkg::s_to_fine(trim_r, cur_exp), new_exp);
        end else if (wr_trim) begin
            trim_r <= cmd_wdata;
        end
    end

    // backup copy at exponent -12, saturated to eight bits
    assign trim_fine = ovs_pkg::s_to_fine(trim_r, cur_exp);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            backup_r <= '0;
        end else if (trim_fine > ovs_pkg::TRIM_NVM_MAX) begin
            backup_r <= ovs_pkg::TRIM_NVM_MAX[7:0];
        end else if (trim_fine < ovs_pkg::TRIM_NVM_MIN) begin
            backup_r <= ovs_pkg::TRIM_NVM_MIN[7:0];
        end else begin
            backup_r <= trim_fine[7:0];
        end
    end

    // ==========================================================
    // target: setpoint plus signed offset, clamped to the limits
    assign sum = $signed({1'b0, ovs_pkg::u_to_fine(sp_r, cur_exp)})
                 + {trim_fine[ovs_pkg::FINE_W-1], trim_fine};

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            target_r <= '0;
            clamp_r  <= 1'b0;
        end else if (sum > $signed({1'b0, vout_max_fine})) begin
            target_r <= vout_max_fine;
            clamp_r  <= 1'b1;
        end else if (sum < $signed({1'b0, vout_min_fine})) begin
            target_r <= vout_min_fine;
            clamp_r  <= 1'b1;
        end else begin
            target_r <= sum[ovs_pkg::FINE_W-1:0];
            clamp_r  <= 1'b0;
        end
    end

    // warning pulses once when a voltage write lands outside the limits
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            upd_r  <= '0;
            warn_r <= 1'b0;
        end else begin
            // two stages: clamp_r settles one cycle after the register write
            upd_r  <= {upd_r[0], wr_sp || wr_trim || wr_fmt};
            warn_r <= upd_r[1] && clamp_r;
        end
    end

    ovs_ref_ramp #(
        .TICK_CYC (RAMP_TICK_CYC)
    ) u_ramp (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .target      (target_r),
        .slew_step   (slew_step),
        .reference_r (reference_fine),
        .ramp_busy   (ramp_busy)
    );

    // ==========================================================
    // command answer, one cycle after the request
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ack_r   <= 1'b0;
            err_r   <= 1'b0;
            rdata_r <= '0;
        end else begin
            ack_r <= cmd_valid;
            err_r <= cmd_valid && !(rd_ok || wr_fmt || wr_sp || wr_trim);
            if (rd_ok) begin
                case (cmd_code)
                    ovs_pkg::CMD_FORMAT:   rdata_r <= {8'h00, fmt_r};
                    ovs_pkg::CMD_SETPOINT: rdata_r <= sp_r;
                    ovs_pkg::CMD_OFFSET:   rdata_r <= trim_r;
                    default:               rdata_r <= '0;
                endcase
            end
        end
    end

    assign cmd_ack         = ack_r;
    assign cmd_error       = err_r;
    assign cmd_rdata       = rdata_r;
    assign boot_voltage    = boot_r;
    assign trim_nvm_backup = backup_r;
    assign target_fine     = target_r;
    assign limit_warning   = warn_r;
    assign limit_clamped   = clamp_r;

    // ==========================================================
    // checks
    property p_fmt_locked;
        @(posedge sys_clk) disable iff (rst)
        (run && !restore_user_all && cmd_valid && cmd_write && is_fmt && conversion_enabled)
            |=> $stable(fmt_r) && cmd_error;
    endproperty
    a_fmt_locked: assert property (p_fmt_locked) else $error("format changed while enabled");

    property p_mode_linear;
        @(posedge sys_clk) disable iff (rst)
        fmt_r[ovs_pkg::FMT_MODE_HI:ovs_pkg::FMT_MODE_LO] == ovs_pkg::MODE_LINEAR
            && ovs_pkg::exp_ok(cur_exp);
    endproperty
    a_mode_linear: assert property (p_mode_linear) else $error("bad mode or exponent held");

    property p_fmt_read;
        @(posedge sys_clk) disable iff (rst)
        (rd_ok && is_fmt) |=> cmd_ack && !cmd_error && cmd_rdata == {8'h00, $past(fmt_r)};
    endproperty
    a_fmt_read: assert property (p_fmt_read) else $error("format read mismatch");

    property p_sp_write;
        @(posedge sys_clk) disable iff (rst)
        (wr_sp && !boot_load && !ext_rst_evt && !fault_evt) |=> sp_r == $past(cmd_wdata);
    endproperty
    a_sp_write: assert property (p_sp_write) else $error("setpoint write lost");

    property p_rel_only;
        @(posedge sys_clk) disable iff (rst)
        (wr_fmt && new_exp == cur_exp && !boot_load && !ext_rst_evt && !fault_evt)
            |=> $stable(sp_r) && $stable(trim_r);
    endproperty
    a_rel_only: assert property (p_rel_only) else $error("relative flag moved setpoint");

    property p_ext_reset;
        @(posedge sys_clk) disable iff (rst)
        (run && !restore_user_all && ext_rst_evt) |=> sp_r == $past(boot_r);
    endproperty
    a_ext_reset: assert property (p_ext_reset) else $error("reset pin did not restore boot");

    property p_fault_keep;
        @(posedge sys_clk) disable iff (rst)
        (run && fault_hiccup && !reload_on_fault_bit && !restore_user_all && !ext_rst_evt
         && !wr_fmt && !wr_sp) |=> $stable(sp_r);
    endproperty
    a_fault_keep: assert property (p_fault_keep) else $error("setpoint lost in hiccup");

    property p_clamp;
        @(posedge sys_clk) disable iff (rst)
        !$past(rst) |-> (target_r <= $past(vout_max_fine)
            || $past(vout_min_fine) > $past(vout_max_fine));
    endproperty
    a_clamp: assert property (p_clamp) else $error("target above upper limit");

    property p_warn;
        @(posedge sys_clk) disable iff (rst)
        (wr_sp || wr_trim) ##2 clamp_r |=> limit_warning;
    endproperty
    a_warn: assert property (p_warn) else $error("limit warning missing");

    c_sp_write:  cover property (@(posedge sys_clk) disable iff (rst) wr_sp ##3 limit_warning);
    c_fmt_write: cover property (@(posedge sys_clk) disable iff (rst) wr_fmt);
    c_ext_reset: cover property (@(posedge sys_clk) disable iff (rst) run && ext_rst_evt);

endmodule

`default_nettype wire

// ===== ovs_host_model.sv
// host model issuing byte and word commands to the setpoint registers
`timescale 1ns/100ps
`default_nettype none
module ovs_host_model (
    input  wire logic        sys_clk,
    output logic             cmd_valid,
    output logic             cmd_write,
    output logic             cmd_word,
    output logic [7:0]       cmd_code,
    output logic [15:0]      cmd_wdata,
    input  wire logic        cmd_ack,
    input  wire logic        cmd_error,
    input  wire logic [15:0] cmd_rdata
);
    initial {cmd_valid, cmd_write, cmd_word, cmd_code, cmd_wdata} = '0;
    // one request per call; idle code and data lines carry inverted values, write and word lines keep the last value
    task automatic xfer(input logic w, input logic wd, input logic [7:0] c,
                        input logic [15:0] d, output logic [15:0] rd, output logic er);
        @(posedge sys_clk);
        {cmd_valid, cmd_write, cmd_word, cmd_code, cmd_wdata} <= {1'b1, w, wd, c, d};
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        {cmd_code, cmd_wdata} <= ~{c, d};
        @(negedge sys_clk);
        rd = cmd_rdata;
        er = cmd_error | ~cmd_ack;
    endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the output voltage setpoint registers
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    typedef struct packed {logic [2:0] f; logic [7:0] c; logic [15:0] d;} ovs_row_t;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid, cmd_write, cmd_word, cmd_ack, cmd_error, er, ramp_busy;
    logic limit_warning, limit_clamped, conversion_enabled, default_source_select;
    logic reload_on_fault_bit, reset_pin_enabled, power_good_or_reset_pin_n;
    logic fault_hiccup, restore_user_all;
    logic [7:0] cmd_code, nvm_format, nvm_trim, trim_nvm_backup;
    logic [15:0] cmd_wdata, cmd_rdata, boot_voltage, rd, nvm_setpoint, slew_step;
    logic [15:0] voltage_select_pin_value;
    logic [ovs_pkg::FINE_W-1:0] vout_max_fine, vout_min_fine, target_fine, reference_fine;
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;
    int k;
    // f holds {write, word, refused}; d is write data or expected read data
    ovs_row_t rows [20] = '{
        '{3'h2, 8'h21, 16'h1000}, '{3'h2, 8'h22, 16'h0005}, '{3'h0, 8'h20, 16'h0014},
        '{3'h6, 8'h21, 16'h1234}, '{3'h2, 8'h21, 16'h1234}, '{3'h6, 8'h22, 16'hFFFE},
        '{3'h1, 8'h21, 16'h0000}, '{3'h5, 8'h20, 16'h0034}, '{3'h5, 8'h20, 16'h000B},
        '{3'h3, 8'h23, 16'h0000}, '{3'h4, 8'h20, 16'h0094}, '{3'h0, 8'h20, 16'h0094},
        '{3'h2, 8'h21, 16'h1234}, '{3'h4, 8'h20, 16'h001C}, '{3'h2, 8'h21, 16'h0012},
        '{3'h2, 8'h22, 16'hFFFF}, '{3'h6, 8'h21, 16'h0010}, '{3'h4, 8'h20, 16'h0014},
        '{3'h2, 8'h21, 16'h1000}, '{3'h6, 8'h22, 16'h0000}};
    ovs_output_voltage_setpoint_regs #(.RAMP_TICK_CYC(2)) ovs_output_voltage_setpoint_regs_i (.*);
    ovs_host_model ovs_host_model_i (.*);
    always #10 sys_clk = ~sys_clk;
    task automatic chk(input string nm, input logic [24:0] seen, input logic [24:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cmd(input ovs_row_t r);
        ovs_host_model_i.xfer(r.f[2], r.f[1], r.c, r.d, rd, er);
        chk("refused", er, r.f[0]);
        if (!r.f[2] && !r.f[0]) chk("rdata", rd, r.d);
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            summarize();
        end
    end
    initial begin
        {conversion_enabled, default_source_select, reload_on_fault_bit} = 3'h0;
        {reset_pin_enabled, power_good_or_reset_pin_n, fault_hiccup, restore_user_all} = 4'h4;
        {nvm_format, nvm_trim, nvm_setpoint, slew_step} = {8'h14, 8'h05, 16'h1000, 16'h0100};
        voltage_select_pin_value = 16'h2000;
        {vout_max_fine, vout_min_fine} = {25'h0_8000, 25'h0_0000};
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("boot_in_reset", boot_voltage, 25'h0);
        @(posedge sys_clk) rst <= 1'b0;
        @(posedge sys_clk);
        foreach (rows[i]) cmd(rows[i]);
        @(posedge sys_clk) conversion_enabled <= 1'b1;
        cmd('{3'h5, 8'h20, 16'h001C});
        cmd('{3'h0, 8'h20, 16'h0014});
        @(posedge sys_clk) conversion_enabled <= 1'b0;
        cmd('{3'h6, 8'h21, 16'h9000});
        k = 0;
        repeat (4) begin
            @(negedge sys_clk);
            k += int'(limit_warning);
        end
        chk("warnings", k[24:0], 25'h1);
        chk("target", target_fine, vout_max_fine);
        chk("clamped", limit_clamped, 1'b1);
        chk("ramping", ramp_busy, 1'b1);
        for (k = 0; k < 1000 && ramp_busy !== 1'b0; k++) @(negedge sys_clk);
        chk("reference", reference_fine, vout_max_fine);
        chk("boot", boot_voltage, 16'h1000);
        @(posedge sys_clk) {reset_pin_enabled, power_good_or_reset_pin_n} <= 2'h2;
        @(posedge sys_clk) power_good_or_reset_pin_n <= 1'b1;
        cmd('{3'h2, 8'h21, 16'h1000});
        cmd('{3'h6, 8'h21, 16'h0500});
        @(posedge sys_clk) fault_hiccup <= 1'b1;
        @(posedge sys_clk) fault_hiccup <= 1'b0;
        cmd('{3'h2, 8'h21, 16'h0500});
        @(posedge sys_clk) {reload_on_fault_bit, default_source_select, fault_hiccup} <= 3'h7;
        @(posedge sys_clk) fault_hiccup <= 1'b0;
        cmd('{3'h2, 8'h21, 16'h2000});
        @(posedge sys_clk) restore_user_all <= 1'b1;
        @(posedge sys_clk) restore_user_all <= 1'b0;
        cmd('{3'h2, 8'h21, 16'h2000});
        chk("boot_pin", boot_voltage, 16'h2000);
        cmd('{3'h6, 8'h22, 16'h0200});
        @(negedge sys_clk);
        chk("trim_backup_hi", trim_nvm_backup, 8'h7F);
        cmd('{3'h6, 8'h22, 16'hFF00});
        @(negedge sys_clk);
        chk("trim_backup_lo", trim_nvm_backup, 8'h80);
        summarize();
    end
endmodule
`default_nettype wire
